// [src/ccm_defines.svh]
`ifndef CCM_DEFINES_SVH
`define CCM_DEFINES_SVH

`define CCM_NSLOT 8
`define CCM_LEVEL_W 12
`define CCM_NPIN 2

// register byte offsets, except the level window base, which is address bits 7:5
`define CCM_REG_CTRL 8'h00
`define CCM_REG_DEB 8'h04
`define CCM_REG_CC1_DBCLR 8'h08
`define CCM_REG_CC2_DBCLR 8'h0c
`define CCM_REG_CC1_HIT_EN 8'h10
`define CCM_REG_CC2_HIT_EN 8'h14
`define CCM_REG_CC1_HITS 8'h18
`define CCM_REG_CC2_HITS 8'h1c
`define CCM_REG_CC1_CHG 8'h20
`define CCM_REG_CC2_CHG 8'h24
`define CCM_REG_INT_STS 8'h28
`define CCM_REG_INT_MASK 8'h2c
`define CCM_REG_STATUS 8'h30
`define CCM_REG_LEVEL_BASE 3'h2

// control fields
`define CCM_CTRL_DBNC_EN 0
`define CCM_CTRL_ROLE 1
`define CCM_CTRL_ADV_LO 2
`define CCM_CTRL_W 4
`define CCM_CTRL_RST 4'h0

// interrupt status fields
`define CCM_INT_VALID 0
`define CCM_INT_CC1_CHG 1
`define CCM_INT_CC2_CHG 2
`define CCM_INT_W 3

`define CCM_MASK_RST 8'hff

// default slot levels in millivolts
`define CCM_LVL0_RST 12'h0c8
`define CCM_LVL1_RST 12'h190
`define CCM_LVL2_RST 12'h294
`define CCM_LVL3_RST 12'h320
`define CCM_LVL4_RST 12'h4ce
`define CCM_LVL5_RST 12'h640
`define CCM_LVL6_RST 12'ha28
`define CCM_LVL7_RST 12'hbb8

// debounce default
`define CCM_CLK_MHZ 250
`define CCM_DEB_TIME_US 10
`define CCM_DEB_CYCLES (`CCM_DEB_TIME_US * `CCM_CLK_MHZ)

`endif

// [src/ccm_pkg.sv]
`include "ccm_defines.svh"

package ccm_pkg;

    typedef enum logic {
        CCM_ROLE_SRC,
        CCM_ROLE_SNK
    } ccm_role_t;

    typedef struct packed {
        logic [1:0] adv;
        ccm_role_t role;
        logic dbnc_en;
    } ccm_cfg_t;

    typedef struct packed {
        logic [`CCM_NSLOT-1:0] stable;
        logic settled;
    } ccm_dbnc_t;

endpackage

// [src/ccm_level_mem.sv]
`timescale 1ns/1ps
`include "ccm_defines.svh"

module ccm_level_mem import ccm_pkg::*; #(
    parameter int DEPTH = `CCM_NSLOT,
    parameter int LW = `CCM_LEVEL_W
) (
    // system
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ce,
    // write port
    input wire logic wr_en,
    input wire logic [2:0] wr_idx,
    input wire logic [LW-1:0] wr_data,
    // read port
    input wire logic [2:0] rd_idx,
    output logic [LW-1:0] rd_data,
    // all levels toward the dac
    output logic [DEPTH*LW-1:0] levels
);

    localparam logic [DEPTH*LW-1:0] RST_LEVELS = {`CCM_LVL7_RST, `CCM_LVL6_RST, `CCM_LVL5_RST,
        `CCM_LVL4_RST, `CCM_LVL3_RST, `CCM_LVL2_RST, `CCM_LVL1_RST, `CCM_LVL0_RST};

    if (DEPTH != 8 || LW != 12) begin : g_chk
        $error("ccm_level_mem supports eight 12-bit slots only");
    end

    logic [LW-1:0] mem_ff [DEPTH];
    logic [LW-1:0] nxt_mem [DEPTH];
    logic [LW-1:0] rd_ff;
    logic [LW-1:0] nxt_rd;

    for (genvar i = 0; i < DEPTH; i++) begin : g_slot
        always_comb begin
            nxt_mem[i] = mem_ff[i];
            if (wr_en && wr_idx == 3'(i)) begin
                nxt_mem[i] = wr_data;
            end
        end

        always_ff @(posedge clk_sys) begin
            if (sys_rst) begin
                mem_ff[i] <= RST_LEVELS[i*LW +: LW];
            end else if (ce) begin
                mem_ff[i] <= nxt_mem[i];
            end
        end

        assign levels[i*LW +: LW] = mem_ff[i];
    end

    always_comb begin
        nxt_rd = mem_ff[rd_idx];
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rd_ff <= '0;
        end else if (ce) begin
            rd_ff <= nxt_rd;
        end
    end

    assign rd_data = rd_ff;

endmodule

// [src/ccm_sync_dbnc.sv]
`timescale 1ns/1ps
`include "ccm_defines.svh"

module ccm_sync_dbnc import ccm_pkg::*; #(
    parameter int W = `CCM_NSLOT,
    parameter int DEB_W = 16
) (
    // system
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ce,
    // control
    input wire logic en,
    input wire logic [W-1:0] clr_mask,
    input wire logic [DEB_W-1:0] deb_len,
    // comparator
    input wire logic [W-1:0] raw,
    // result
    output ccm_dbnc_t res
);

    if (W != `CCM_NSLOT || DEB_W < 2) begin : g_chk
        $error("ccm_sync_dbnc width mismatch");
    end

    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] cand_ff;
    logic [W-1:0] nxt_cand;
    logic [W-1:0] stab_ff;
    logic [W-1:0] nxt_stab;
    logic [DEB_W-1:0] cnt_ff;
    logic [DEB_W-1:0] nxt_cnt;
    logic set_ff;
    logic nxt_set;

    // two-stage synchroniser per comparator
    for (genvar i = 0; i < W; i++) begin : g_sync
        always_ff @(posedge clk_sys) begin
            if (sys_rst) begin
                s1_ff[i] <= 1'b0;
                s2_ff[i] <= 1'b0;
            end else if (ce) begin
                s1_ff[i] <= raw[i];
                s2_ff[i] <= s1_ff[i];
            end
        end
    end

    always_comb begin
        nxt_cand = s2_ff;
        nxt_cnt = cnt_ff;
        nxt_stab = stab_ff;
        nxt_set = set_ff;
        if (!en) begin
            nxt_cnt = '0;
            nxt_set = 1'b0;
        end else if (((s2_ff ^ cand_ff) & clr_mask) != '0) begin
            // a watched slot moved: restart the interval
            nxt_cnt = '0;
        end else if (cnt_ff >= deb_len) begin
            nxt_stab = cand_ff;
            nxt_set = 1'b1;
        end else begin
            nxt_cnt = cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cand_ff <= '0;
            cnt_ff <= '0;
            stab_ff <= '0;
            set_ff <= 1'b0;
        end else if (ce) begin
            cand_ff <= nxt_cand;
            cnt_ff <= nxt_cnt;
            stab_ff <= nxt_stab;
            set_ff <= nxt_set;
        end
    end

    assign res.stable = stab_ff;
    assign res.settled = set_ff;

endmodule

// [src/ccm_threshold_match.sv]
`timescale 1ns/1ps
`include "ccm_defines.svh"

// Operation
// - each cc pin has eight level slots 0 to 7 and hit bit k reports slot k.
// - slots 0 to 6 reset to ascending low levels and slot 7 to the top vendor level.
// - in sink role changes of exceeded source levels are tracked so software can read the source current.
// - slot 5 is the sink-attach level for default and mid sources, slot 6 for high.
// - slot 0 is the powered-cable level at default and the sink default-source level, slots 1 and 3 the cable mid/high.
// - a source facing only a powered cable reads all hit bits zero.
// - a source with a sink attached sees only bit 0, 1 or 3 for default, mid or high.
// - a source with an open pin sees bits 0+5, 1+5, 3+6, or 7 alone in vendor mode.
// - a sink sees bit 0, bits 0+2, or bits 0+2+4 for default, mid or high sources.
// - a sink sees bits 0,2,4,7 for a vendor source, and nothing for open or cable alone.
// - with 0x22 in both masks and a mid source with an open pin only bits 1 and 5 set in hits and changes after debounce.
// - hits and changes update after the debounce interval, or at once on a hit-enable write, and from the same crossing.
// - with 0x15 in both masks a sink facing a high source sets bits 0, 2 and 4 in hits and changes.
// - initial_hits_valid rises once both pins finished their first debounce and hits are valid.
module ccm_threshold_match import ccm_pkg::*; #(
    parameter int NSLOT = `CCM_NSLOT,
    parameter int LW = `CCM_LEVEL_W,
    parameter int DEB_W = 16,
    parameter logic [15:0] DEB_RST = 16'(`CCM_DEB_CYCLES)
) (
    // system
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ce,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // comparator outputs, bit k high while pin is above slot k
    input wire logic [NSLOT-1:0] cc1_above,
    input wire logic [NSLOT-1:0] cc2_above,
    // analog setup
    output logic [NSLOT*LW-1:0] cc_level_slots,
    output ccm_cfg_t analog_cfg,
    // status
    output logic initial_hits_valid,
    output logic irq
);

    if (NSLOT != 8 || LW != 12 || DEB_W != 16) begin : g_chk
        $error("ccm_threshold_match supports 8 slots, 12-bit levels, 16-bit debounce");
    end

    localparam int NP = `CCM_NPIN;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw,
                                                input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // bus request
    logic ack_ff;
    logic nxt_ack;
    logic [31:0] dat_ff;
    logic [31:0] nxt_dat;
    logic req;
    logic wr_req;
    logic rd_req;
    logic lvl_hit;
    logic [2:0] lvl_idx;

    // configuration
    logic [`CCM_CTRL_W-1:0] ctrl_ff;
    logic [`CCM_CTRL_W-1:0] nxt_ctrl;
    logic [DEB_W-1:0] deb_ff;
    logic [DEB_W-1:0] nxt_deb;
    logic [NSLOT-1:0] dbclr_ff [NP];
    logic [NSLOT-1:0] nxt_dbclr [NP];
    logic [NSLOT-1:0] hit_en_ff [NP];
    logic [NSLOT-1:0] nxt_hit_en [NP];
    logic [`CCM_INT_W-1:0] imask_ff;
    logic [`CCM_INT_W-1:0] nxt_imask;
    logic lvl_we;
    logic [LW-1:0] lvl_wdata;
    logic [LW-1:0] lvl_rdata;

    // results
    ccm_dbnc_t dbo [NP];
    logic [NSLOT-1:0] hits_ff [NP];
    logic [NSLOT-1:0] nxt_hits [NP];
    logic [NSLOT-1:0] chg_ff [NP];
    logic [NSLOT-1:0] nxt_chg [NP];
    logic [NSLOT-1:0] chg_set [NP];
    logic [NP-1:0] chg_clr;
    logic valid_ff;
    logic nxt_valid;
    logic [`CCM_INT_W-1:0] ists_ff;
    logic [`CCM_INT_W-1:0] nxt_ists;
    logic [`CCM_INT_W-1:0] ists_set;
    logic [NSLOT-1:0] raw [NP];

    assign req = wb_cyc_i && wb_stb_i && !ack_ff;
    // writes land on the edge that completes the cycle, with ack already high
    assign wr_req = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff;
    assign rd_req = req && !wb_we_i;
    assign lvl_hit = wb_adr_i[7:5] == `CCM_REG_LEVEL_BASE;
    assign lvl_idx = wb_adr_i[4:2];
    assign raw[0] = cc1_above;
    assign raw[1] = cc2_above;

    ccm_level_mem #(
        .DEPTH(NSLOT),
        .LW(LW)
    ) u_levels (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .ce(ce),
        .wr_en(lvl_we),
        .wr_idx(lvl_idx),
        .wr_data(lvl_wdata),
        .rd_idx(lvl_idx),
        .rd_data(lvl_rdata),
        .levels(cc_level_slots)
    );

    for (genvar p = 0; p < NP; p++) begin : g_pin
        ccm_sync_dbnc #(
            .W(NSLOT),
            .DEB_W(DEB_W)
        ) u_dbnc (
            .clk_sys(clk_sys),
            .sys_rst(sys_rst),
            .ce(ce),
            .en(ctrl_ff[`CCM_CTRL_DBNC_EN]),
            .clr_mask(dbclr_ff[p]),
            .deb_len(deb_ff),
            .raw(raw[p]),
            .res(dbo[p])
        );

        always_comb begin
            nxt_hits[p] = dbo[p].stable & hit_en_ff[p];
            chg_set[p] = nxt_hits[p] ^ hits_ff[p];
            // a new change beats a clearing read in the same cycle
            nxt_chg[p] = (chg_ff[p] & ~{NSLOT{chg_clr[p]}}) | chg_set[p];
        end

        always_ff @(posedge clk_sys) begin
            if (sys_rst) begin
                hits_ff[p] <= '0;
                chg_ff[p] <= '0;
            end else if (ce) begin
                hits_ff[p] <= nxt_hits[p];
                chg_ff[p] <= nxt_chg[p];
            end
        end
    end

    // register writes
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_deb = deb_ff;
        nxt_dbclr = dbclr_ff;
        nxt_hit_en = hit_en_ff;
        nxt_imask = imask_ff;
        lvl_we = wr_req && lvl_hit;
        lvl_wdata = LW'(merge_bytes(32'(cc_level_slots[lvl_idx*LW +: LW]), wb_dat_i, wb_sel_i));
        if (wr_req) begin
            case (wb_adr_i)
                `CCM_REG_CTRL: nxt_ctrl = `CCM_CTRL_W'(merge_bytes(32'(ctrl_ff), wb_dat_i, wb_sel_i));
                `CCM_REG_DEB: nxt_deb = DEB_W'(merge_bytes(32'(deb_ff), wb_dat_i, wb_sel_i));
                `CCM_REG_CC1_DBCLR: nxt_dbclr[0] = NSLOT'(merge_bytes(32'(dbclr_ff[0]), wb_dat_i, wb_sel_i));
                `CCM_REG_CC2_DBCLR: nxt_dbclr[1] = NSLOT'(merge_bytes(32'(dbclr_ff[1]), wb_dat_i, wb_sel_i));
                `CCM_REG_CC1_HIT_EN: nxt_hit_en[0] = NSLOT'(merge_bytes(32'(hit_en_ff[0]), wb_dat_i, wb_sel_i));
                `CCM_REG_CC2_HIT_EN: nxt_hit_en[1] = NSLOT'(merge_bytes(32'(hit_en_ff[1]), wb_dat_i, wb_sel_i));
                `CCM_REG_INT_MASK: nxt_imask = `CCM_INT_W'(merge_bytes(32'(imask_ff), wb_dat_i, wb_sel_i));
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl_ff <= `CCM_CTRL_RST;
            deb_ff <= DEB_RST;
            dbclr_ff <= '{default: `CCM_MASK_RST};
            hit_en_ff <= '{default: `CCM_MASK_RST};
            imask_ff <= '0;
        end else if (ce) begin
            ctrl_ff <= nxt_ctrl;
            deb_ff <= nxt_deb;
            dbclr_ff <= nxt_dbclr;
            hit_en_ff <= nxt_hit_en;
            imask_ff <= nxt_imask;
        end
    end

    // validity and interrupt status
    always_comb begin
        nxt_valid = ctrl_ff[`CCM_CTRL_DBNC_EN] && dbo[0].settled && dbo[1].settled;
        chg_clr[0] = rd_req && wb_adr_i == `CCM_REG_CC1_CHG;
        chg_clr[1] = rd_req && wb_adr_i == `CCM_REG_CC2_CHG;
        ists_set = '0;
        ists_set[`CCM_INT_VALID] = nxt_valid && !valid_ff;
        ists_set[`CCM_INT_CC1_CHG] = |chg_set[0];
        ists_set[`CCM_INT_CC2_CHG] = |chg_set[1];
        nxt_ists = ists_ff;
        if (rd_req && wb_adr_i == `CCM_REG_INT_STS) begin
            nxt_ists = '0;
        end
        nxt_ists = nxt_ists | ists_set;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            valid_ff <= 1'b0;
            ists_ff <= '0;
        end else if (ce) begin
            valid_ff <= nxt_valid;
            ists_ff <= nxt_ists;
        end
    end

    // read data and acknowledge
    always_comb begin
        nxt_ack = req;
        nxt_dat = dat_ff;
        if (rd_req) begin
            case (wb_adr_i)
                `CCM_REG_CTRL: nxt_dat = 32'(ctrl_ff);
                `CCM_REG_DEB: nxt_dat = 32'(deb_ff);
                `CCM_REG_CC1_DBCLR: nxt_dat = 32'(dbclr_ff[0]);
                `CCM_REG_CC2_DBCLR: nxt_dat = 32'(dbclr_ff[1]);
                `CCM_REG_CC1_HIT_EN: nxt_dat = 32'(hit_en_ff[0]);
                `CCM_REG_CC2_HIT_EN: nxt_dat = 32'(hit_en_ff[1]);
                `CCM_REG_CC1_HITS: nxt_dat = 32'(hits_ff[0]);
                `CCM_REG_CC2_HITS: nxt_dat = 32'(hits_ff[1]);
                `CCM_REG_CC1_CHG: nxt_dat = 32'(chg_ff[0]);
                `CCM_REG_CC2_CHG: nxt_dat = 32'(chg_ff[1]);
                `CCM_REG_INT_STS: nxt_dat = 32'(ists_ff);
                `CCM_REG_INT_MASK: nxt_dat = 32'(imask_ff);
                `CCM_REG_STATUS: nxt_dat = {30'h0000_0000, ctrl_ff[`CCM_CTRL_DBNC_EN], valid_ff};
                default: nxt_dat = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ack_ff <= 1'b0;
            dat_ff <= '0;
        end else if (ce) begin
            ack_ff <= nxt_ack;
            dat_ff <= nxt_dat;
        end
    end

    // level reads come from the memory's own output register
    assign wb_dat_o = (lvl_hit && !wb_we_i) ? 32'(lvl_rdata) : dat_ff;
    assign wb_ack_o = ack_ff;
    assign analog_cfg.dbnc_en = ctrl_ff[`CCM_CTRL_DBNC_EN];
    assign analog_cfg.role = ccm_role_t'(ctrl_ff[`CCM_CTRL_ROLE]);
    assign analog_cfg.adv = ctrl_ff[`CCM_CTRL_ADV_LO +: 2];
    assign initial_hits_valid = valid_ff;
    assign irq = |(ists_ff & imask_ff);

endmodule

// [testbench/ccm_threshold_match_asserts.sv]
`timescale 1ns/1ps
`include "ccm_defines.svh"
module ccm_threshold_match_asserts import ccm_pkg::*; #(
    parameter int NSLOT = 8,
    parameter int LW = 12,
    parameter logic [15:0] DEB_RST = 16'h0004
) (
    // system
    input wire logic clk_sys,
    input wire logic sys_rst,
    // wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // pins and status
    input wire logic [NSLOT-1:0] cc1_above,
    input wire logic [NSLOT-1:0] cc2_above,
    input wire logic [NSLOT*LW-1:0] cc_level_slots,
    input wire ccm_cfg_t analog_cfg,
    input wire logic initial_hits_valid,
    input wire logic irq
);
    logic [15:0] quiet_ff;
    logic [15:0] nxt_quiet;
    logic [2*NSLOT-1:0] above_ff;
    logic [2*NSLOT-1:0] nxt_above;

    // cycles since the last comparator change, saturating
    always_comb begin
        nxt_above = {cc2_above, cc1_above};
        nxt_quiet = quiet_ff + {15'h0, quiet_ff != 16'hffff};
        if (sys_rst || above_ff != nxt_above) begin
            nxt_quiet = 16'h0000;
        end
    end
    always_ff @(posedge clk_sys) begin
        quiet_ff <= nxt_quiet;
        above_ff <= nxt_above;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    AST_ACK_LAT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked next cycle");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_UNMAPPED: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h5f |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    AST_LEVEL_W: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:5] == 3'h2 |-> wb_dat_o[31:12] == 20'h0)
        else $error("level slot upper bits set");
    AST_LEVEL_RST: assert property ($fell(sys_rst) |-> cc_level_slots == {`CCM_LVL7_RST, `CCM_LVL6_RST,
        `CCM_LVL5_RST, `CCM_LVL4_RST, `CCM_LVL3_RST, `CCM_LVL2_RST, `CCM_LVL1_RST, `CCM_LVL0_RST})
        else $error("level slots not at defaults");
    AST_VALID_QUIET: assert property ($rose(initial_hits_valid) |-> quiet_ff >= DEB_RST)
        else $error("valid before debounce");
    AST_VALID_EN: assert property ($rose(initial_hits_valid) |-> analog_cfg.dbnc_en)
        else $error("valid with debouncer off");
    AST_IRQ_HOLD: assert property ($fell(irq) |-> (wb_ack_o && !wb_we_i && wb_adr_i == 8'h28)
        || $past(wb_ack_o && wb_we_i && wb_adr_i == 8'h2c))
        else $error("irq dropped without a clear");
    AST_CFG_WR: assert property (!$stable(analog_cfg) |-> $past(wb_we_i && wb_stb_i && wb_adr_i == 8'h00))
        else $error("analog setup changed without write");
endmodule

// [testbench/ccm_cc_partner.sv]
`timescale 1ns/1ps
module ccm_cc_partner import ccm_pkg::*; (
    // block analog setup
    input wire ccm_cfg_t cfg,
    // pin state: 0 open, 1 powered cable, 2 partner attached
    input wire logic [1:0] st1,
    input wire logic [1:0] st2,
    // comparator bits
    output logic [7:0] cc1_above,
    output logic [7:0] cc2_above
);
    localparam logic [7:0] SRC_ATT [4] = '{8'h01, 8'h02, 8'h08, 8'h00};
    localparam logic [7:0] SRC_OPEN [4] = '{8'h21, 8'h22, 8'h48, 8'h80};
    localparam logic [7:0] SNK_ATT [4] = '{8'h01, 8'h05, 8'h15, 8'h95};

    function automatic logic [7:0] pins(input ccm_cfg_t c, input logic [1:0] st);
        if (st == 2'h1) return 8'h00;
        if (c.role == CCM_ROLE_SNK) return (st == 2'h2) ? SNK_ATT[c.adv] : 8'h00;
        return (st == 2'h2) ? SRC_ATT[c.adv] : SRC_OPEN[c.adv];
    endfunction

    assign cc1_above = pins(cfg, st1);
    assign cc2_above = pins(cfg, st2);
endmodule

// [testbench/cc_threshold_match_logic_tb.sv]
`timescale 1ns/1ps
module cc_threshold_match_logic_tb import ccm_pkg::*;;
    localparam logic [15:0] DEB = 16'h0004;
    localparam logic [11:0] LVL [8] = '{12'h0c8, 12'h190, 12'h294, 12'h320, 12'h4ce, 12'h640, 12'ha28, 12'hbb8};
    // role, advertised level, pin state, expected hits
    localparam logic [15:0] CASES [16] = '{16'h0100, 16'h0500, 16'h0900, 16'h0201, 16'h0602, 16'h0a08, 16'h0021,
        16'h0422, 16'h0848, 16'h0c80, 16'h1201, 16'h1605, 16'h1a15, 16'h1e95, 16'h1800, 16'h1900};
    logic clk_sys;
    logic sys_rst;
    logic wb_cyc;
    logic wb_stb;
    logic wb_we;
    logic [7:0] wb_adr;
    logic [31:0] wb_wdat;
    logic [3:0] wb_sel;
    logic ce;
    logic [31:0] wb_rdat;
    logic wb_ack;
    logic [7:0] cc1_above;
    logic [7:0] cc2_above;
    logic [95:0] levels;
    ccm_cfg_t cfg;
    logic valid;
    logic irq;
    logic [1:0] st1;
    logic [1:0] st2;
    logic [31:0] rd;
    int n_errors;
    int cmp_count;

    ccm_threshold_match #(.DEB_RST(DEB)) i_ccm_threshold_match (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat), .wb_sel_i(wb_sel), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .cc1_above(cc1_above), .cc2_above(cc2_above), .cc_level_slots(levels), .analog_cfg(cfg),
        .initial_hits_valid(valid), .irq(irq));
    ccm_cc_partner i_ccm_cc_partner (.cfg(cfg), .st1(st1), .st2(st2), .cc1_above(cc1_above),
        .cc2_above(cc2_above));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd, input logic [3:0] sel = 4'hf);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_wdat <= wd;
        wb_sel <= sel;
        @(posedge clk_sys);
        while (wb_ack !== 1'b1 && n < 50) begin
            @(posedge clk_sys);
            n++;
        end
        if (n == 50) check(32'h1, 32'h0);
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rchk(input logic [7:0] adr, input logic [31:0] exp);
        xfer(1'b0, adr, 32'h0);
        check(rd, exp);
    endtask

    task automatic test_defaults();
        for (int k = 0; k < 8; k++) begin
            rchk(8'h40 + 8'(4 * k), {20'h0, LVL[k]});
            check({20'h0, levels[12 * k +: 12]}, {20'h0, LVL[k]});
        end
        rchk(8'h00, 32'h0);
        rchk(8'h08, 32'hff);
        rchk(8'h14, 32'hff);
        rchk(8'h2c, 32'h0);
        rchk(8'h80, 32'h0);
        xfer(1'b1, 8'h48, 32'hffff_fabc);
        rchk(8'h48, 32'h0000_0abc);
        check({20'h0, levels[35:24]}, 32'h0abc);
        xfer(1'b1, 8'h48, 32'h0000_0f12, 4'h1);
        rchk(8'h48, 32'h0000_0a12);
        xfer(1'b1, 8'h48, 32'h294);
    endtask

    task automatic test_valid();
        int n;
        xfer(1'b1, 8'h2c, 32'h7);
        xfer(1'b1, 8'h00, 32'h1);
        n = 0;
        while (valid !== 1'b1 && n < 200) begin
            @(posedge clk_sys);
            n++;
        end
        check({31'h0, valid}, 32'h1);
        check({31'h0, irq}, 32'h1);
        xfer(1'b0, 8'h28, 32'h0);
        check(rd & 32'h1, 32'h1);
        xfer(1'b0, 8'h20, 32'h0);
        xfer(1'b0, 8'h24, 32'h0);
        rchk(8'h28, 32'h0);
        check({31'h0, irq}, 32'h0);
    endtask

    task automatic test_patterns();
        logic [7:0] prev;
        logic [15:0] c;
        prev = 8'h21;
        for (int i = 0; i < 16; i++) begin
            c = CASES[i];
            xfer(1'b1, 8'h00, {28'h0, c[11:10], c[12], 1'b1});
            check({28'h0, cfg}, {28'h0, c[11:10], c[12], 1'b1});
            st1 <= c[9:8];
            st2 <= c[9:8];
            repeat (2 * DEB + 8) @(posedge clk_sys);
            check({31'h0, irq}, {31'h0, prev != c[7:0]});
            rchk(8'h18, {24'h0, c[7:0]});
            rchk(8'h1c, {24'h0, c[7:0]});
            rchk(8'h20, {24'h0, prev ^ c[7:0]});
            rchk(8'h24, {24'h0, prev ^ c[7:0]});
            rchk(8'h20, 32'h0);
            rchk(8'h28, {29'h0, {2{prev != c[7:0]}}, 1'b0});
            prev = c[7:0];
        end
    endtask

    task automatic test_masks();
        for (int a = 8; a < 24; a += 4) xfer(1'b1, 8'(a), 32'h22);
        xfer(1'b1, 8'h00, 32'h5);
        st1 <= 2'h0;
        st2 <= 2'h1;
        repeat (2 * DEB + 8) @(posedge clk_sys);
        rchk(8'h18, 32'h22);
        rchk(8'h1c, 32'h0);
        rchk(8'h24, 32'h0);
        rchk(8'h20, 32'h22);
        for (int a = 8; a < 24; a += 4) xfer(1'b1, 8'(a), 32'h15);
        xfer(1'b1, 8'h00, 32'hb);
        st2 <= 2'h0;
        repeat (2 * DEB + 8) @(posedge clk_sys);
        xfer(1'b0, 8'h20, 32'h0);
        xfer(1'b0, 8'h28, 32'h0);
        st1 <= 2'h2;
        rchk(8'h18, 32'h0);
        repeat (2 * DEB + 8) @(posedge clk_sys);
        rchk(8'h18, 32'h15);
        rchk(8'h20, 32'h15);
        xfer(1'b1, 8'h2c, 32'h0);
        xfer(1'b1, 8'h10, 32'h1);
        repeat (2 * DEB + 8) @(posedge clk_sys);
        check({31'h0, irq}, 32'h0);
        rchk(8'h18, 32'h1);
        xfer(1'b1, 8'h2c, 32'h7);
        check({31'h0, irq}, 32'h1);
        rchk(8'h28, 32'h2);
        check({31'h0, irq}, 32'h0);
    endtask

    task automatic test_freeze();
        ce <= 1'b0;
        st1 <= 2'h0;
        repeat (2 * DEB + 8) @(posedge clk_sys);
        check({31'h0, irq}, 32'h0);
        ce <= 1'b1;
        rchk(8'h18, 32'h1);
        repeat (2 * DEB + 8) @(posedge clk_sys);
        rchk(8'h18, 32'h0);
    endtask

    task automatic test_done();
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        test_done();
    end

    initial begin
        n_errors = 0;
        cmp_count = 0;
        sys_rst = 1'b1;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 8'h00;
        wb_wdat = 32'h0;
        wb_sel = 4'h0;
        ce = 1'b1;
        st1 = 2'h0;
        st2 = 2'h0;
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        test_defaults();
        test_valid();
        test_patterns();
        test_masks();
        test_freeze();
        test_done();
    end
endmodule

bind ccm_threshold_match ccm_threshold_match_asserts #(.NSLOT(NSLOT), .LW(LW), .DEB_RST(DEB_RST)) i_asserts (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cc1_above(cc1_above), .cc2_above(cc2_above),
    .cc_level_slots(cc_level_slots), .analog_cfg(analog_cfg), .initial_hits_valid(initial_hits_valid), .irq(irq));
